// ==== hw/mpb_top.sv ====
// Motor preheat and mechanical brake sequencer of an AC drive.
// Assumes frequency, current and temperature words come from logic on this clock;
// digital inputs come from pins and are synchronised here.
`timescale 1ns/10ps
module mpb_top #(
    parameter int FW = 16,
    parameter int TW = 12,
    parameter int CW = 24,
    parameter int NDI = 8,
    parameter int NMT = 4
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic drive_stopped,
    input wire logic run_cmd,
    input wire logic magn_done,
    input wire logic [2:0] preheat_function_select,
    input wire logic signed [TW-1:0] preheat_temperature_limit,
    input wire logic [1:0] motor_temperature_source,
    input wire logic [2:0] preheat_request_input_select,
    input wire logic signed [TW-1:0] heatsink_temp,
    input wire logic [NMT-1:0][TW-1:0] motor_temp,
    input wire logic [NDI-1:0] dig_in,
    input wire logic [1:0] brake_control_select,
    input wire logic [CW-1:0] brake_mechanical_delay,
    input wire logic [CW-1:0] brake_feedback_timeout,
    input wire logic [FW-1:0] brake_open_frequency_limit,
    input wire logic [FW-1:0] brake_close_frequency_limit,
    input wire logic [FW-1:0] brake_current_limit,
    input wire logic [FW-1:0] field_weak_freq,
    input wire logic [2:0] brake_feedback_input_select,
    input wire logic signed [FW-1:0] freq_ref_in,
    input wire logic signed [FW-1:0] output_freq,
    input wire logic [FW-1:0] motor_current,
    input wire logic fault_clear,
    output logic preheat_on,
    output logic brake_open,
    output logic signed [FW-1:0] freq_ref_out,
    output logic [15:0] app_status_word1,
    output logic brake_fault,
    output logic [7:0] fault_code
);
    import mpb_pkg::*;

    typedef struct packed {
        mpb_brake_st_t st;
        logic [CW-1:0] dly;
        logic [CW-1:0] fbt;
        logic heat;
        logic brake;
        logic fault;
        logic [7:0] code;
        logic signed [FW-1:0] ref_out;
        logic [15:0] stat;
    } mpb_top_st_t;

    mpb_top_st_t q, d;
    logic [NDI-1:0] di_s;
    logic fb_open;
    logic heat_req;
    logic [FW-1:0] absf;
    logic [FW-1:0] eff_lim;
    logic low_cur;
    logic [2*FW-1:0] prod;

    // ==========================================================
    // Pin inputs
    // Digital inputs come straight from terminals, so they are synchronised first.
    mpb_sync #(.W(NDI)) u_di_sync (
        .clock(clock),
        .nrst(nrst),
        .din(dig_in),
        .dout(di_s)
    );

    // ==========================================================
    // Derived measurements
    // A closed contact means the brake is open.
    assign fb_open = di_s[brake_feedback_input_select];
    // The closing and opening limits act on the magnitude.
    assign absf = output_freq[FW-1] ? FW'(-output_freq) : FW'(output_freq);

    // Above field weakening start the current limit falls as 1/f.
    // A divider is costly, but it only sees slow configuration and speed words.
    always_comb begin
        prod = brake_current_limit * field_weak_freq;
        if (absf > field_weak_freq && absf != '0) begin
            eff_lim = FW'(prod / absf);
        end else begin
            eff_lim = brake_current_limit;
        end
        low_cur = motor_current < eff_lim;
    end

    // ==========================================================
    // Preheat request
    // Every mode also needs the stopped state, so leaving stop ends heating.
    always_comb begin
        case (preheat_function_select)
            MPB_PH_ALWAYS: heat_req = 1'b1;
            MPB_PH_INPUT: heat_req = di_s[preheat_request_input_select];
            MPB_PH_SINK: heat_req = heatsink_temp < preheat_temperature_limit;
            MPB_PH_MOTOR: heat_req = $signed(motor_temp[motor_temperature_source])
                < preheat_temperature_limit;
            default: heat_req = 1'b0;
        endcase
        heat_req = heat_req & drive_stopped;
    end

    // ==========================================================
    // Brake sequencer
    always_comb begin
        d = q;
        d.heat = heat_req;
        case (q.st)
            BR_IDLE: begin
                d.brake = 1'b0;
                d.dly = '0;
                d.fbt = '0;
                if (run_cmd && !q.fault) begin
                    d.st = BR_MAGN;
                end
            end
            // Reference held at zero while the rotor flux builds.
            BR_MAGN: begin
                if (!run_cmd) begin
                    d.st = BR_IDLE;
                end else if (magn_done) begin
                    d.st = BR_RAMP;
                end
            end
            // Reference may rise to the opening limit; the brake opens there.
            BR_RAMP: begin
                if (!run_cmd) begin
                    d.st = BR_IDLE;
                end else if (absf >= brake_open_frequency_limit) begin
                    d.st = BR_HOLD;
                    d.brake = 1'b1;
                end
            end
            // Reference clamped until the mechanics have had time to lift.
            BR_HOLD: begin
                if (q.dly != brake_mechanical_delay) begin
                    d.dly = q.dly + CW'(1);
                end
                if (!run_cmd) begin
                    d.st = BR_STOP;
                end else if (q.dly == brake_mechanical_delay &&
                    (brake_control_select != MPB_BR_SUPV || fb_open)) begin
                    d.st = BR_RUN;
                end
            end
            BR_RUN: begin
                if (!run_cmd) begin
                    d.st = BR_STOP;
                end
            end
            // Closing happens once the drive has slowed down, unless low current or a new fault closes it first.
            BR_STOP: begin
                if (absf < brake_close_frequency_limit) begin
                    d.st = BR_IDLE;
                    d.brake = 1'b0;
                end else if (run_cmd) begin
                    d.st = BR_RUN;
                end
            end
            default: d.st = BR_IDLE;
        endcase

        // Low current drops the brake at once in any open state.
        if ((q.st == BR_HOLD || q.st == BR_RUN || q.st == BR_STOP) && low_cur) begin
            d.st = BR_IDLE;
            d.brake = 1'b0;
        end

        // Feedback must confirm opening within the timeout.
        if (brake_control_select == MPB_BR_SUPV && q.brake && !fb_open) begin
            d.fbt = q.fbt + CW'(1);
        end else begin
            d.fbt = '0;
        end
        // A new fault wins over a clear arriving in the same cycle.
        d.fault = (q.fault && !fault_clear) ||
            (brake_control_select == MPB_BR_SUPV && q.brake && !fb_open &&
             q.fbt >= brake_feedback_timeout);
        if (d.fault && !q.fault) begin
            d.st = BR_IDLE;
            d.brake = 1'b0;
        end
        d.code = d.fault ? MPB_FAULT_BRAKE : MPB_FAULT_NONE;

        // Brake function off: output idle, reference passes.
        if (brake_control_select == MPB_BR_OFF) begin
            d.st = BR_IDLE;
            d.brake = 1'b0;
        end

        // Reference shaping follows the state being entered.
        if (brake_control_select == MPB_BR_OFF) begin
            d.ref_out = freq_ref_in;
        end else begin
            case (d.st)
                BR_RAMP: begin
                    if (freq_ref_in > $signed({1'b0, brake_open_frequency_limit})) begin
                        d.ref_out = $signed(brake_open_frequency_limit);
                    end else if (freq_ref_in < -$signed({1'b0, brake_open_frequency_limit})) begin
                        d.ref_out = -$signed(brake_open_frequency_limit);
                    end else begin
                        d.ref_out = freq_ref_in;
                    end
                end
                BR_HOLD: d.ref_out = freq_ref_in[FW-1] ? -$signed(brake_open_frequency_limit)
                    : $signed(brake_open_frequency_limit);
                BR_RUN, BR_STOP: d.ref_out = freq_ref_in;
                default: d.ref_out = '0;
            endcase
        end

        // Status word carries the brake command.
        d.stat = MPB_STAT_RST;
        d.stat[MPB_STAT_BRAKE_OPEN] = d.brake;
        d.stat[MPB_STAT_PREHEAT] = d.heat;
        d.stat[MPB_STAT_RELEASED] = d.st == BR_RUN;
        d.stat[MPB_STAT_FAULT] = d.fault;
    end

    // ==========================================================
    // Registers
    // Reset leaves the brake closed and the heater off.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign preheat_on = q.heat;
    assign brake_open = q.brake;
    assign freq_ref_out = q.ref_out;
    assign app_status_word1 = q.stat;
    assign brake_fault = q.fault;
    assign fault_code = q.code;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    preheat_sel_off_a: assert property (
        preheat_function_select == MPB_PH_OFF |=> !preheat_on)
        else $error("Preheat active with selection zero.");
    preheat_stop_only_a: assert property (
        !drive_stopped |=> !preheat_on)
        else $error("Preheat active while drive not stopped.");
    preheat_always_a: assert property (
        nrst && preheat_function_select == MPB_PH_ALWAYS && drive_stopped |=> preheat_on)
        else $error("Preheat missing in always mode.");
    brake_mode_off_a: assert property (
        nrst && brake_control_select == MPB_BR_OFF |=> !brake_open && freq_ref_out == $past(freq_ref_in))
        else $error("Brake driven or reference altered with brake off.");
    magn_ref_zero_a: assert property (
        q.st == BR_MAGN |-> freq_ref_out == '0 && !brake_open)
        else $error("Reference not held during magnetisation.");
    hold_clamp_a: assert property (
        q.st == BR_HOLD && $past(q.st) == BR_HOLD |->
        (freq_ref_out == $signed($past(brake_open_frequency_limit)) ||
         freq_ref_out == -$signed($past(brake_open_frequency_limit))))
        else $error("Reference not clamped at opening limit.");
    release_fb_a: assert property (
        q.st == BR_HOLD && brake_control_select == MPB_BR_SUPV && !fb_open |=> q.st != BR_RUN)
        else $error("Released without brake feedback.");
    low_current_a: assert property (
        q.st == BR_RUN && low_cur |=> !brake_open)
        else $error("Brake left open at low current.");
    close_freq_a: assert property (
        q.st == BR_STOP && absf < brake_close_frequency_limit |=> !brake_open)
        else $error("Brake not closed below closing limit.");
    fault_code_a: assert property (
        $rose(brake_fault) |-> fault_code == MPB_FAULT_BRAKE && !brake_open)
        else $error("Wrong fault code or brake open on fault.");
    status_bit_a: assert property (
        app_status_word1[MPB_STAT_BRAKE_OPEN] == brake_open)
        else $error("Status word disagrees with brake output.");
    status_heat_a: assert property (
        app_status_word1[MPB_STAT_PREHEAT] == preheat_on)
        else $error("Status word disagrees with preheat.");
    status_rel_a: assert property (
        app_status_word1[MPB_STAT_RELEASED] == (q.st == BR_RUN))
        else $error("Status released bit wrong.");

    // The sampled reset term keeps the edge that releases reset from starting a check.
    preheat_input_a: assert property (
        nrst && preheat_function_select == MPB_PH_INPUT && drive_stopped
        |=> preheat_on == $past(di_s[preheat_request_input_select]))
        else $error("Preheat ignores its request input.");
    preheat_sink_a: assert property (
        nrst && preheat_function_select == MPB_PH_SINK && drive_stopped
        |=> preheat_on == $past(heatsink_temp < preheat_temperature_limit))
        else $error("Preheat ignores heatsink limit.");
    preheat_motor_a: assert property (
        nrst && preheat_function_select == MPB_PH_MOTOR && drive_stopped
        |=> preheat_on == $past($signed(motor_temp[motor_temperature_source]) < preheat_temperature_limit))
        else $error("Preheat ignores motor limit.");

    // Opening and release; brake off forces idle, so it is left out here.
    magn_wait_a: assert property (
        q.st == BR_MAGN && run_cmd && !magn_done && brake_control_select != MPB_BR_OFF
        |=> q.st == BR_MAGN)
        else $error("Left magnetisation early.");
    ramp_clamp_a: assert property (
        q.st == BR_RAMP |->
        freq_ref_out <= $signed({1'b0, $past(brake_open_frequency_limit)}) &&
        freq_ref_out >= -$signed({1'b0, $past(brake_open_frequency_limit)}))
        else $error("Ramp reference above opening limit.");
    open_freq_a: assert property (
        q.st == BR_RAMP && run_cmd && absf >= brake_open_frequency_limit &&
        brake_control_select != MPB_BR_OFF |=> brake_open)
        else $error("Brake not opened at opening limit.");
    plain_release_a: assert property (
        q.st == BR_HOLD && run_cmd && !low_cur && brake_control_select == MPB_BR_ON &&
        q.dly == brake_mechanical_delay |=> q.st == BR_RUN)
        else $error("Plain mode release waits.");
    run_pass_a: assert property (
        q.st == BR_RUN |-> freq_ref_out == $past(freq_ref_in))
        else $error("Reference clamped after release.");

    // Closing and the feedback fault.
    close_cur_a: assert property (
        (q.st == BR_HOLD || q.st == BR_STOP) && low_cur |=> !brake_open)
        else $error("Brake left open at low current.");
    fault_set_a: assert property (
        brake_control_select == MPB_BR_SUPV && brake_open && !fb_open &&
        q.fbt >= brake_feedback_timeout |=> brake_fault && !brake_open)
        else $error("Feedback timeout gave no fault.");
    fault_hold_a: assert property (
        brake_fault && !fault_clear |=> brake_fault && q.st == BR_IDLE)
        else $error("Start accepted while faulted.");
    fault_clear_a: assert property (
        brake_fault && fault_clear && !brake_open |=> !brake_fault)
        else $error("Fault not cleared.");

    run_reached_c: cover property (q.st == BR_HOLD ##[1:1000] q.st == BR_RUN);
    stop_close_c: cover property (q.st == BR_STOP ##1 q.st == BR_IDLE);
    fault_seen_c: cover property ($rose(brake_fault));
    motor_heat_c: cover property (preheat_function_select == MPB_PH_MOTOR && preheat_on);
    fw_limit_c: cover property (absf > field_weak_freq && q.st == BR_RUN);
endmodule // mpb_top

// ==== hw/mpb_pkg.sv ====
// Constants, encodings and state types shared by the preheat and brake block.
// Assumes one system clock; all configuration arrives as plain ports.
// Functional notes
// - Preheat selection zero never drives preheat current.
// - Preheat commands DC current and exists only while the drive is stopped.
// - Selection one heats whenever the drive is stopped.
// - Selection two heats while stopped and the chosen request input is high.
// - Selection three heats while stopped and heatsink is below the limit.
// - Selection four heats while stopped and motor temperature is below the limit.
// - Brake selection zero leaves brake output idle and reference untouched.
// - Brake selection one drives the brake and ignores feedback.
// - Brake selection two drives the brake and watches the feedback input.
// - Brake opens and closes by comparing output frequency with the limits.
// - After start, reference waits for magnetisation, then rises to opening limit.
// - After open command, reference stays at opening limit until delay expires.
// - With feedback supervision, release needs expired delay and correct feedback.
// - After release, the normal reference passes without clamping.
// - After stop, brake closes when output frequency falls below closing limit.
// - Closing limit compares against frequency magnitude, both directions.
// - Brake closes at once when motor current is below the current limit.
// - Above field weakening start, the current limit shrinks with frequency.
// - Brake state is reported in the first application status word.
// - Feedback contact closed means brake open, open means brake closed.
// - Missing feedback after open command raises mechanical brake fault 58.
package mpb_pkg;

    // Preheat selection codes.
    localparam logic [2:0] MPB_PH_OFF = 3'h0;
    localparam logic [2:0] MPB_PH_ALWAYS = 3'h1;
    localparam logic [2:0] MPB_PH_INPUT = 3'h2;
    localparam logic [2:0] MPB_PH_SINK = 3'h3;
    localparam logic [2:0] MPB_PH_MOTOR = 3'h4;

    // Brake control selection codes.
    localparam logic [1:0] MPB_BR_OFF = 2'h0;
    localparam logic [1:0] MPB_BR_ON = 2'h1;
    localparam logic [1:0] MPB_BR_SUPV = 2'h2;

    // Status word bit positions.
    localparam int MPB_STAT_BRAKE_OPEN = 0;
    localparam int MPB_STAT_PREHEAT = 1;
    localparam int MPB_STAT_RELEASED = 2;
    localparam int MPB_STAT_FAULT = 3;

    // Fault code for a brake that never confirms opening.
    localparam logic [7:0] MPB_FAULT_BRAKE = 8'h3a;
    localparam logic [7:0] MPB_FAULT_NONE = 8'h00;
    localparam logic [15:0] MPB_STAT_RST = 16'h0000;

    typedef enum logic [2:0] {
        BR_IDLE,
        BR_MAGN,
        BR_RAMP,
        BR_HOLD,
        BR_RUN,
        BR_STOP
    } mpb_brake_st_t;

endpackage

// ==== hw/mpb_sync.sv ====
// Two-stage synchroniser for a group of pin-level inputs.
// Assumes the inputs are levels that change slowly against the clock.
`timescale 1ns/10ps
module mpb_sync #(
    parameter int W = 8
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } mpb_sync_st_t;

    mpb_sync_st_t q, d;

    // The first stage feeds only the second stage.
    always_comb begin
        d = q;
        d.s1 = din;
        d.s2 = q.s1;
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign dout = q.s2;
endmodule // mpb_sync

// ==== tb/mpb_brake_model.sv ====
// Behavioural model of the mechanical brake and its auxiliary feedback contact.
// Assumes the brake command comes from the block under test on the same clock.
`timescale 1ns/10ps
// =====================================================================
// Brake actuator with a slow mechanical response
// =====================================================================
module mpb_brake_model #(
    parameter int RESP = 6
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic brake_cmd,
    input wire logic stuck,
    output logic contact
);
    int cnt_q;

    // The contact closes only once the brake has really opened, and opens at once on closing.
    // A stuck brake never opens, so its contact stays open; the bench uses this to provoke a fault.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 0;
            contact <= 1'b0;
        end else if (brake_cmd && !stuck) begin
            if (cnt_q == RESP) begin
                contact <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 1;
            end
        end else begin
            cnt_q <= 0;
            contact <= 1'b0;
        end
    end
endmodule // mpb_brake_model

// ==== tb/test_motor_preheat_brake_control.sv ====
// Self-checking bench for the preheat and brake sequencer.
// Assumes the block package and the brake model are compiled first.
`timescale 1ns/10ps
module test_motor_preheat_brake_control;
    import mpb_pkg::*;
    logic clock = 1'b0, nrst = 1'b0, drive_stopped = 1'b1, run_cmd = 1'b0, magn_done = 1'b0;
    logic [2:0] preheat_function_select = 3'h1;
    logic [11:0] heatsink_temp = 12'h000, preheat_temperature_limit = 12'h014;
    logic [3:0][11:0] motor_temp = '0;
    logic req_bit = 1'b0, fault_clear = 1'b0, stuck = 1'b0, fb_contact;
    logic [1:0] brake_control_select = 2'h0;
    logic [15:0] freq_ref_in = 16'h0000, output_freq = 16'h0000, motor_current = 16'h012c;
    logic preheat_on, brake_open, brake_fault;
    logic [15:0] freq_ref_out, app_status_word1;
    logic [7:0] fault_code;
    int mismatches = 0, cmp_count = 0;
    logic [1:0] mt_src = 2'h1;
    logic [2:0] req_sel = 3'h2, fb_sel = 3'h5;
    logic [23:0] mech_delay = 24'h000004;

    // 20 MHz system clock.
    always #25 clock = ~clock;

    mpb_top i_mpb_top (.clock(clock), .nrst(nrst), .drive_stopped(drive_stopped), .run_cmd(run_cmd),
        .magn_done(magn_done), .preheat_function_select(preheat_function_select),
        .preheat_temperature_limit(preheat_temperature_limit), .motor_temperature_source(mt_src),
        .preheat_request_input_select(req_sel), .heatsink_temp(heatsink_temp), .motor_temp(motor_temp),
        .dig_in({2'h0, fb_contact, 2'h0, req_bit, 2'h0}), .brake_control_select(brake_control_select),
        .brake_mechanical_delay(mech_delay), .brake_feedback_timeout(24'h000014),
        .brake_open_frequency_limit(16'h0064), .brake_close_frequency_limit(16'h0014),
        .brake_current_limit(16'h0064), .field_weak_freq(16'h00c8),
        .brake_feedback_input_select(fb_sel), .freq_ref_in(freq_ref_in), .output_freq(output_freq),
        .motor_current(motor_current), .fault_clear(fault_clear), .preheat_on(preheat_on),
        .brake_open(brake_open), .freq_ref_out(freq_ref_out), .app_status_word1(app_status_word1),
        .brake_fault(brake_fault), .fault_code(fault_code));

    mpb_brake_model i_mpb_brake_model (.clock(clock), .nrst(nrst), .brake_cmd(brake_open),
        .stuck(stuck), .contact(fb_contact));

    // =====================================================================
    // Shared tasks
    // =====================================================================
    // Waits n edges and lets their updates land before anything is sampled.
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Sets one preheat case; three edges cover the input synchroniser on the request pin.
    task automatic ph(input logic [2:0] sel, input logic req, input logic [11:0] hs, input logic [11:0] mt1,
        input logic [11:0] oth, input logic exp);
        @(posedge clock);
        preheat_function_select <= sel;
        req_bit <= req;
        heatsink_temp <= hs;
        motor_temp <= {oth, oth, mt1, oth};
        settle(3);
        check("preheat_on", 16'(preheat_on), 16'(exp));
        check("status_preheat", 16'(app_status_word1[MPB_STAT_PREHEAT]), 16'(exp));
    endtask

    // Start, magnetisation and ramp up to the opening limit, ending just after the edge that registers the open command.
    task automatic start_run(input logic [1:0] sel, input logic stk);
        @(posedge clock);
        brake_control_select <= sel;
        stuck <= stk;
        run_cmd <= 1'b1;
        freq_ref_in <= 16'h03e8;
        settle(2);
        check("ref_magn", freq_ref_out, 16'h0000);
        @(posedge clock);
        magn_done <= 1'b1;
        settle(2);
        check("ref_ramp", freq_ref_out, 16'h0064);
        @(posedge clock);
        output_freq <= 16'h0064;
        settle(1);
        check("brake_open", 16'(brake_open), 16'h0001);
    endtask

    task automatic stop_run;
        @(posedge clock);
        run_cmd <= 1'b0;
        magn_done <= 1'b0;
        output_freq <= 16'h0000;
        motor_current <= 16'h012c;
        stuck <= 1'b0;
        settle(4);
    endtask

    // =====================================================================
    // Watchdog: the whole sequence needs about 150 cycles
    // =====================================================================
    initial begin
        repeat (3000) @(posedge clock);
        mismatches++;
        complete_run;
    end

    // =====================================================================
    // Test sequence
    // =====================================================================
    initial begin
        settle(2);
        check("preheat_rst", 16'(preheat_on), 16'h0000);
        check("brake_rst", 16'(brake_open), 16'h0000);
        @(posedge clock);
        nrst <= 1'b1;
        ph(3'h0, 1'b1, 12'h00a, 12'h005, 12'h000, 1'b0);
        ph(3'h1, 1'b0, 12'h01e, 12'h019, 12'h064, 1'b1);
        ph(3'h2, 1'b0, 12'h00a, 12'h005, 12'h000, 1'b0);
        ph(3'h2, 1'b1, 12'h01e, 12'h019, 12'h064, 1'b1);
        ph(3'h3, 1'b1, 12'h01e, 12'h005, 12'h000, 1'b0);
        ph(3'h3, 1'b0, 12'h00a, 12'h019, 12'h064, 1'b1);
        ph(3'h4, 1'b1, 12'h00a, 12'h019, 12'h000, 1'b0);
        ph(3'h4, 1'b0, 12'h01e, 12'h005, 12'h064, 1'b1);
        @(posedge clock);
        drive_stopped <= 1'b0;
        settle(1);
        check("preheat_leave", 16'(preheat_on), 16'h0000);
        $display("test preheat done");
        // Brake control off: no output and the reference passes unshaped.
        @(posedge clock);
        preheat_function_select <= 3'h0;
        run_cmd <= 1'b1;
        magn_done <= 1'b1;
        output_freq <= 16'h0064;
        freq_ref_in <= 16'h03e8;
        settle(4);
        check("brake_off", 16'(brake_open), 16'h0000);
        check("ref_off", freq_ref_out, 16'h03e8);
        stop_run;
        $display("test brake off done");
        // Plain mode with a stuck brake: feedback is ignored, close uses the magnitude.
        start_run(2'h1, 1'b1);
        check("status_open", 16'(app_status_word1[MPB_STAT_BRAKE_OPEN]), 16'h0001);
        settle(1);
        check("ref_hold", freq_ref_out, 16'h0064);
        settle(6);
        check("ref_run", freq_ref_out, 16'h03e8);
        check("status_rel", 16'(app_status_word1[MPB_STAT_RELEASED]), 16'h0001);
        check("fault_m1", 16'(brake_fault), 16'h0000);
        @(posedge clock);
        run_cmd <= 1'b0;
        output_freq <= 16'hffce;
        settle(3);
        check("open_neg", 16'(brake_open), 16'h0001);
        @(posedge clock);
        output_freq <= 16'hfff6;
        settle(1);
        check("close_neg", 16'(brake_open), 16'h0000);
        stop_run;
        $display("test brake plain done");
        // Supervised mode: release waits for the contact; low current closes at once.
        start_run(2'h2, 1'b0);
        settle(6);
        check("ref_wait_fb", freq_ref_out, 16'h0064);
        settle(8);
        check("ref_fb_ok", freq_ref_out, 16'h03e8);
        check("fault_ok", 16'(brake_fault), 16'h0000);
        @(posedge clock);
        output_freq <= 16'h0190;
        motor_current <= 16'h0046;
        settle(3);
        check("open_fw", 16'(brake_open), 16'h0001);
        @(posedge clock);
        motor_current <= 16'h0028;
        settle(1);
        check("close_cur", 16'(brake_open), 16'h0000);
        stop_run;
        $display("test brake supervised done");
        // Supervised mode with a brake that never opens: timeout raises the fault.
        start_run(2'h2, 1'b1);
        settle(24);
        check("fault_set", 16'(brake_fault), 16'h0001);
        check("fault_code", 16'(fault_code), 16'(MPB_FAULT_BRAKE));
        check("fault_stat", 16'(app_status_word1[MPB_STAT_FAULT]), 16'h0001);
        check("fault_close", 16'(brake_open), 16'h0000);
        stop_run;
        @(posedge clock);
        fault_clear <= 1'b1;
        settle(2);
        check("fault_clr", 16'(fault_code), 16'h0000);
        check("fault_off", 16'(brake_fault), 16'h0000);
        @(posedge clock);
        fault_clear <= 1'b0;
        $display("test brake fault done");
        complete_run;
    end
endmodule // test_motor_preheat_brake_control
